// File: hw/qs_sram.sv
`timescale 1ns/1ps
`include "qs_regs.svh"

// Operation
// - Write data sampled on both clock rises
// - Low write select at K starts write
// - Deselected write port ignores write data
// - Disabled lane leaves stored byte unchanged
// - Lanes map nine-bit slices low to high
// - Lane enables sampled with their data beat
// - Read address at K, write at K-bar
// - Nineteen address bits, one burst location each (the model stores only 16 locations, indexed by the low 4 address bits)
// - Address ignored when its port deselected
// - Read words driven on both clock rises
// - Deselected read port floats data outputs
// - Low read select at K starts read
// - Pending burst finishes, then outputs float
// - Each read returns exactly two words
// - Valid flag edge-aligned with echo clocks
// - Accesses begin on K rising edge
// - K-bar rise captures inputs, launches data
// - Free-running echo clocks follow K
// - PLL off selects single-cycle latency timing
// - Two words per input clock cycle

module qs_sram (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic read_port_sel_n,
    input wire logic write_port_sel_n,
    input wire logic [`QS_AW-1:0] addr,
    input wire logic [`QS_LANES-1:0] byte_lane_en_n,
    input wire logic [`QS_DW-1:0] wr_data,
    input wire logic pll_off_n,
    output logic [`QS_DW-1:0] rd_data,
    output logic rd_data_oe,
    output logic out_valid_flag,
    output logic echo_clk,
    output logic echo_clk_n
);

    // ----------------------------------------------------------------
    // Input clock edge detection
    // ----------------------------------------------------------------
    // K and K-bar are sampled as ordinary inputs; mclk must run well
    // above them so that every rise is seen.
    logic k_d_r;
    logic kn_d_r;
    logic k_rise;
    logic kn_rise;

    assign k_rise = k_clk && !k_d_r;
    assign kn_rise = k_clk_n && !kn_d_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            k_d_r <= 1'b0;
            kn_d_r <= 1'b0;
        end else begin
            k_d_r <= k_clk;
            kn_d_r <= k_clk_n;
        end
    end

    // ----------------------------------------------------------------
    // Storage and lane merge
    // ----------------------------------------------------------------
    qs_pkg::qs_word_t mem0_r [`QS_STORE_DEPTH];
    qs_pkg::qs_word_t mem1_r [`QS_STORE_DEPTH];

    function automatic qs_pkg::qs_word_t lane_merge(input qs_pkg::qs_word_t old_w,
                                                    input qs_pkg::qs_beat_s beat);
        qs_pkg::qs_word_t res;
        res = old_w;
        for (int i = 0; i < `QS_LANES; i++) begin
            if (!beat.lane_n[i]) begin
                res[i*`QS_LANE_W +: `QS_LANE_W] = beat.data[i*`QS_LANE_W +: `QS_LANE_W];
            end
        end
        return res;
    endfunction

    function automatic logic [`QS_STORE_AW-1:0] store_idx(input logic [`QS_AW-1:0] a);
        // Only the low bits index the modelled slice; any pin permutation
        // is harmless as long as reads and writes use the same one.
        return a[`QS_STORE_AW-1:0];
    endfunction

    // ----------------------------------------------------------------
    // Write port
    // ----------------------------------------------------------------
    logic wr_act_r;
    qs_pkg::qs_beat_s beat0_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_act_r <= 1'b0;
            beat0_r <= '0;
        end else if (k_rise) begin
            wr_act_r <= !write_port_sel_n;
            if (!write_port_sel_n) begin
                beat0_r <= '{data: wr_data, lane_n: byte_lane_en_n};
            end
        end else if (kn_rise) begin
            wr_act_r <= 1'b0;
        end
    end

    // Commit both beats at the K-bar rise that carries the write address
    always_ff @(posedge mclk) begin
        if (kn_rise && wr_act_r) begin
            mem0_r[store_idx(addr)] <= lane_merge(mem0_r[store_idx(addr)], beat0_r);
            mem1_r[store_idx(addr)] <= lane_merge(mem1_r[store_idx(addr)],
                                                  '{data: wr_data, lane_n: byte_lane_en_n});
        end
    end

    // ----------------------------------------------------------------
    // Read port: fetch burst into FIFO
    // ----------------------------------------------------------------
    logic rd_pend_r;
    logic rd_half_r;
    logic [`QS_STORE_AW-1:0] rd_idx_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [`QS_FIFO_CW-1:0] fifo_count;
    qs_pkg::qs_word_t fifo_in_data;
    qs_pkg::qs_word_t fifo_out_data;
    logic fifo_push;

    assign fifo_push = rd_pend_r;
    assign fifo_in_data = rd_half_r ? mem1_r[rd_idx_r] : mem0_r[rd_idx_r];

    // A full FIFO stalls the fetch; the pending read waits, never drops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_r <= 1'b0;
            rd_half_r <= 1'b0;
            rd_idx_r <= '0;
        end else if (rd_pend_r) begin
            if (fifo_in_ready) begin
                rd_half_r <= !rd_half_r;
                rd_pend_r <= !rd_half_r;
            end
        end else if (k_rise && !read_port_sel_n) begin
            rd_pend_r <= 1'b1;
            rd_half_r <= 1'b0;
            rd_idx_r <= store_idx(addr);
        end
    end

    qs_fifo #(
        .W(`QS_DW),
        .D(`QS_FIFO_DEPTH),
        .PW(`QS_FIFO_PW),
        .CW(`QS_FIFO_CW)
    ) i_qs_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ----------------------------------------------------------------
    // Read output launch
    // ----------------------------------------------------------------
    // PLL on launches the first word on K-bar (half-cycle phase);
    // PLL off uses the older timing and launches on K.
    qs_pkg::qs_out_e out_st_r;
    logic first_edge;
    logic second_edge;
    logic burst_ready;

    assign first_edge = pll_off_n ? kn_rise : k_rise;
    assign second_edge = pll_off_n ? k_rise : kn_rise;
    assign burst_ready = (fifo_count >= `QS_BURST_WORDS);
    // Second word is only taken while one is really queued
    assign fifo_pop = (out_st_r != qs_pkg::QS_OUT_FIRST) ? (first_edge && burst_ready)
                                                          : (second_edge && fifo_out_valid);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_st_r <= qs_pkg::QS_OUT_IDLE;
            rd_data <= '0;
            rd_data_oe <= 1'b0;
            out_valid_flag <= 1'b0;
        end else begin
            unique case (out_st_r)
                qs_pkg::QS_OUT_IDLE, qs_pkg::QS_OUT_SECOND: begin
                    if (first_edge && burst_ready) begin
                        out_st_r <= qs_pkg::QS_OUT_FIRST;
                        rd_data <= fifo_out_data;
                        rd_data_oe <= 1'b1;
                        out_valid_flag <= 1'b1;
                    end else if (first_edge || k_rise) begin
                        out_st_r <= qs_pkg::QS_OUT_IDLE;
                        rd_data_oe <= 1'b0;
                        out_valid_flag <= 1'b0;
                    end
                end
                qs_pkg::QS_OUT_FIRST: begin
                    if (second_edge) begin
                        out_st_r <= qs_pkg::QS_OUT_SECOND;
                        rd_data <= fifo_out_data;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Echo clocks
    // ----------------------------------------------------------------
    // Same register stage as the valid flag, so both change on one edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            echo_clk <= 1'b0;
            echo_clk_n <= 1'b1;
        end else begin
            echo_clk <= k_clk;
            echo_clk_n <= !k_clk;
        end
    end

endmodule

// File: hw/qs_regs.svh
`ifndef QS_REGS_SVH
`define QS_REGS_SVH

// Wide configuration widths
`define QS_DW 36
`define QS_AW 19
`define QS_LANES 4
`define QS_LANE_W 9

// Flip-flop storage only models a small slice of the array
`define QS_STORE_AW 4
`define QS_STORE_DEPTH 16

// Read word FIFO
`define QS_FIFO_DEPTH 8
`define QS_FIFO_PW 3
`define QS_FIFO_CW 4

// Words that must be queued before a burst launches
`define QS_BURST_WORDS 4'h2

`endif

// File: hw/qs_pkg.sv
`include "qs_regs.svh"

package qs_pkg;

    typedef logic [`QS_DW-1:0] qs_word_t;
    typedef logic [`QS_LANES-1:0] qs_lane_t;

    // One write beat with its lane enables
    typedef struct packed {
        qs_word_t data;
        qs_lane_t lane_n;
    } qs_beat_s;

    // Read output phase
    typedef enum logic [1:0] {
        QS_OUT_IDLE,
        QS_OUT_FIRST,
        QS_OUT_SECOND
    } qs_out_e;

endpackage

// File: hw/qs_fifo.sv
`timescale 1ns/1ps
`include "qs_regs.svh"

module qs_fifo #(
    parameter int W = `QS_DW,
    parameter int D = `QS_FIFO_DEPTH,
    parameter int PW = `QS_FIFO_PW,
    parameter int CW = `QS_FIFO_CW
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [CW-1:0] count
);

    logic [W-1:0] mem_r [D];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != CW'(D));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign count = count_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + PW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + CW'(1);
            end else if (pop && !push) begin
                count_r <= count_r - CW'(1);
            end
        end
    end

endmodule

// File: tb/qs_sram_sva.sv
`timescale 1ns/1ps
`include "qs_regs.svh"
module qs_sram_sva (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic read_port_sel_n,
    input wire logic pll_off_n,
    input wire logic [`QS_DW-1:0] rd_data,
    input wire logic rd_data_oe,
    input wire logic out_valid_flag,
    input wire logic echo_clk,
    input wire logic echo_clk_n
);
    // ----------------
    // Edge helpers
    // ----------------
    logic k_r, kn_r, krise_r, kbrise_r;
    logic [5:0] rd_age_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // A rise flag lags the pin by one mclk, so outputs may trail it by one more
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            k_r <= 1'b0;
            kn_r <= 1'b0;
            krise_r <= 1'b0;
            kbrise_r <= 1'b0;
            rd_age_r <= 6'h3f;
        end else begin
            k_r <= k_clk;
            kn_r <= k_clk_n;
            krise_r <= k_clk & ~k_r;
            kbrise_r <= k_clk_n & ~kn_r;
            rd_age_r <= (k_clk & ~k_r & ~read_port_sel_n) ? 6'h00 : rd_age_r + {5'h00, rd_age_r != 6'h3f};
        end
    end
    property p_echo; echo_clk == $past(k_clk); endproperty
    a_echo: assert property (p_echo) else $error("echo clock not one cycle behind");
    property p_echo_n; echo_clk_n == !echo_clk; endproperty
    a_echo_n: assert property (p_echo_n) else $error("echo pair not complementary");
    property p_oe; rd_data_oe == out_valid_flag; endproperty
    a_oe: assert property (p_oe) else $error("drive enable differs from valid");
    property p_len; $rose(out_valid_flag) |-> out_valid_flag[*4]; endproperty
    a_len: assert property (p_len) else $error("burst shorter than two words");
    property p_launch; $rose(out_valid_flag) |-> (pll_off_n ? (kbrise_r || $past(kbrise_r))
        : (krise_r || $past(krise_r))); endproperty
    a_launch: assert property (p_launch) else $error("burst launched on wrong edge");
    property p_change; $changed(rd_data) && out_valid_flag && $past(out_valid_flag)
        |-> krise_r || $past(krise_r) || kbrise_r || $past(kbrise_r); endproperty
    a_change: assert property (p_change) else $error("read word changed off clock edge");
    property p_fall; $fell(rd_data_oe) |-> krise_r || $past(krise_r) || kbrise_r || $past(kbrise_r); endproperty
    a_fall: assert property (p_fall) else $error("outputs floated off clock edge");
    property p_cause; $rose(out_valid_flag) |-> rd_age_r < 6'h28; endproperty
    a_cause: assert property (p_cause) else $error("burst without read select");
endmodule
bind qs_sram qs_sram_sva i_qs_sram_sva (.mclk(mclk), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .read_port_sel_n(read_port_sel_n), .pll_off_n(pll_off_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .out_valid_flag(out_valid_flag), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n));

// File: tb/qs_ctl_model.sv
`timescale 1ns/1ps
`include "qs_regs.svh"
module qs_ctl_model (
    input wire logic mclk,
    input wire logic rst_b,
    output logic k_clk,
    output logic k_clk_n,
    output logic read_port_sel_n,
    output logic write_port_sel_n,
    output logic [`QS_AW-1:0] addr,
    output logic [`QS_LANES-1:0] byte_lane_en_n,
    output logic [`QS_DW-1:0] wr_data
);
    // ----------------
    // Input clocks, two mclk per half period, held low in reset
    // ----------------
    logic [1:0] ph_r;
    logic run_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ph_r <= 2'h1;
            run_r <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'h1;
            run_r <= 1'b1;
        end
    end
    assign k_clk = run_r & ~ph_r[1];
    assign k_clk_n = run_r & ph_r[1];
    initial begin
        read_port_sel_n = 1'b1;
        write_port_sel_n = 1'b1;
        addr = '0;
        byte_lane_en_n = '1;
        wr_data = '0;
    end
    // Bounded: the phase counter wraps every four edges
    task automatic to_ph(input logic [1:0] p);
        @(posedge mclk);
        for (int i = 0; i < 4 && ph_r != p - 2'h1; i++) begin
            @(posedge mclk);
        end
    endtask
    // Released lines show the inverse so stale values never look valid
    task automatic do_write(input logic sel_n, input logic [`QS_AW-1:0] ad, input logic [`QS_DW-1:0] a,
        input logic [`QS_DW-1:0] b, input logic [`QS_LANES-1:0] l0, input logic [`QS_LANES-1:0] l1);
        to_ph(2'h0);
        write_port_sel_n <= sel_n;
        wr_data <= a;
        byte_lane_en_n <= l0;
        to_ph(2'h2);
        addr <= ad;
        wr_data <= b;
        byte_lane_en_n <= l1;
        to_ph(2'h0);
        write_port_sel_n <= 1'b1;
        wr_data <= ~b;
        byte_lane_en_n <= ~l1;
        addr <= ~ad;
    endtask
    task automatic do_read(input logic [`QS_AW-1:0] ad);
        to_ph(2'h0);
        read_port_sel_n <= 1'b0;
        addr <= ad;
        to_ph(2'h2);
        read_port_sel_n <= 1'b1;
        addr <= ~ad;
    endtask
endmodule

// File: tb/dual_port_ddr_sram_pin_interface_tb.sv
`timescale 1ns/1ps
`include "qs_regs.svh"
module dual_port_ddr_sram_pin_interface_tb;
    logic mclk, rst_b, pll_off_n, k_clk, k_clk_n, read_port_sel_n, write_port_sel_n;
    logic rd_data_oe, out_valid_flag, echo_clk, echo_clk_n;
    logic [`QS_AW-1:0] addr;
    logic [`QS_LANES-1:0] byte_lane_en_n;
    logic [`QS_DW-1:0] wr_data, rd_data;
    int failures, tests_run;
    always #2.5 mclk = ~mclk;
    qs_ctl_model i_qs_ctl_model (.mclk(mclk), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n), .addr(addr),
        .byte_lane_en_n(byte_lane_en_n), .wr_data(wr_data));
    qs_sram i_qs_sram (.mclk(mclk), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n), .addr(addr),
        .byte_lane_en_n(byte_lane_en_n), .wr_data(wr_data), .pll_off_n(pll_off_n), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe), .out_valid_flag(out_valid_flag), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n));
    // ----------------
    // Shared checks
    // ----------------
    task automatic check(input logic [`QS_DW-1:0] seen, input logic [`QS_DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Word spacing is two mclk because each clock half period is two mclk
    task automatic read_check(input logic [`QS_AW-1:0] ad, input logic [`QS_DW-1:0] w0,
        input logic [`QS_DW-1:0] w1);
        int n;
        i_qs_ctl_model.do_read(ad);
        n = 0;
        while (out_valid_flag !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 40) begin
                failures++;
                final_report();
            end
        end
        check(rd_data, w0);
        check({35'h0, rd_data_oe}, 36'h1);
        check({34'h0, echo_clk, echo_clk_n}, {34'h0, !pll_off_n, pll_off_n});
        repeat (2) @(posedge mclk);
        #1;
        check(rd_data, w1);
        check({35'h0, out_valid_flag}, 36'h1);
        repeat (4) @(posedge mclk);
        #1;
        check({35'h0, out_valid_flag}, 36'h0);
        check({35'h0, rd_data_oe}, 36'h0);
    endtask
    task automatic scen_rw(input logic [`QS_DW-1:0] a);
        i_qs_ctl_model.do_write(1'b0, 19'h00003, a, ~a, 4'h0, 4'h0);
        read_check(19'h00003, a, ~a);
    endtask
    task automatic scen_desel(input logic [`QS_DW-1:0] a);
        i_qs_ctl_model.do_write(1'b1, 19'h00003, 36'h0, 36'hfffffffff, 4'h0, 4'h0);
        read_check(19'h00003, a, ~a);
    endtask
    // One lane per beat, different lanes on the two beats
    task automatic scen_lanes;
        for (int i = 0; i < 4; i++) begin
            i_qs_ctl_model.do_write(1'b0, 19'h00005, 36'h0, 36'h0, 4'h0, 4'h0);
            i_qs_ctl_model.do_write(1'b0, 19'h00005, '1, '1, ~(4'h1 << i), ~(4'h1 << ((i + 1) % 4)));
            read_check(19'h00005, 36'h1ff << (9 * i), 36'h1ff << (9 * ((i + 1) % 4)));
        end
    endtask
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        pll_off_n = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        scen_rw(36'h123456789);
        scen_desel(36'h123456789);
        scen_lanes();
        @(posedge mclk);
        pll_off_n <= 1'b0;
        repeat (8) @(posedge mclk);
        scen_rw(36'h0a5a5a5a5);
        final_report();
    end
endmodule
